// [design/rurc_defines.vh]
// constants for the remote upgrade reconfiguration controller
`ifndef RURC_DEFINES_VH
`define RURC_DEFINES_VH
`define RURC_SRC_EXT 30
`define RURC_SRC_CRC 29
`define RURC_SRC_STAT 28
`define RURC_SRC_WD 27
`define RURC_SRC_CORE 26
`define RURC_MSM_HI 25
`define RURC_MSM_LO 24
`define RURC_ADDR_HI 23
`define RURC_ADDR_LO 0
`define RURC_REC_W 31
`define RURC_INVALID_REC 31'h7FFFFFFF
`define RURC_CTL_W 41
`define RURC_CTL_EARLY 40
`define RURC_CTL_OSC 39
`define RURC_CTL_WDEN 38
`define RURC_CTL_WD_HI 37
`define RURC_CTL_WD_LO 26
`define RURC_CTL_AD_HI 23
`define RURC_CTL_AD_LO 0
`define RURC_WD_W 29
`define RURC_WD_SET_W 12
`define RURC_WD_LOW_W 17
`define RURC_MSM_FACTORY 2'h0
`define RURC_MSM_APP_CFG 2'h1
`define RURC_MSM_APP_USER 2'h2
`define RURC_MSM_FACT_CFG 2'h3
`define RURC_OSC_NOM_KHZ 10000
`define RURC_OSC_MIN_KHZ 5000
`endif

// [design/rurc_source_pick.v]
// priority pick of the reconfiguration source, one-hot result
`timescale 1ns/1ps
module rurc_source_pick #(
	parameter W = 5
)(
	input wire [W-1:0] req,
	output reg [W-1:0] onehot
);
	integer i;
	reg found;
	always @*
	begin
		onehot = {W{1'b0}};
		found = 1'b0;
		for (i = W - 1; i >= 0; i = i - 1)
		begin
			if (req[i] && !found)
			begin
				onehot[i] = 1'b1;
				found = 1'b1;
			end
		end
	end
endmodule

// [design/rurc_watchdog.v]
// user watchdog down-counter on the oscillator tick
`timescale 1ns/1ps
`include "rurc_defines.vh"
module rurc_watchdog #(
	parameter SET_W = `RURC_WD_SET_W,
	parameter LOW_W = `RURC_WD_LOW_W
)(
	input wire ref_clk,
	input wire reset_n,
	input wire enable,
	input wire osc_tick,
	input wire reload,
	input wire [SET_W-1:0] setting,
	output reg expired
);
	reg [SET_W+LOW_W-1:0] count_reg;
	always @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			count_reg <= {(SET_W+LOW_W){1'b0}};
			expired <= 1'b0;
		end
		else if (!enable || reload)
		begin
			count_reg <= {setting, {LOW_W{1'b0}}};
			expired <= 1'b0;
		end
		else if (osc_tick && !expired)
		begin
			if (count_reg == {(SET_W+LOW_W){1'b0}})
				expired <= 1'b1;
			else
				count_reg <= count_reg - {{(SET_W+LOW_W-1){1'b0}}, 1'b1};
		end
	end
endmodule

// [design/rurc_ctrl.v]
// remote upgrade reconfiguration controller top
`timescale 1ns/1ps
`include "rurc_defines.vh"
module rurc_ctrl #(
	parameter CFG_CYCLES = 16
)(
	input wire ref_clk,
	input wire reset_n,
	input wire external_reconfig_request_n,
	input wire config_fault_status_n,
	input wire crc_error,
	input wire core_reconfig_trigger_n,
	input wire watchdog_reload_n,
	input wire osc_tick,
	input wire update_write,
	input wire [`RURC_CTL_W-1:0] update_wdata,
	input wire capture_record_one,
	input wire capture_record_two,
	output reg [`RURC_CTL_W-1:0] reg_rdata,
	output reg [`RURC_REC_W-1:0] record_rdata,
	output reg [`RURC_REC_W-1:0] earlier_exit_record_one,
	output reg [`RURC_REC_W-1:0] earlier_exit_record_two,
	output reg [1:0] msm_state,
	output reg factory_loaded,
	output reg watchdog_expired_flag,
	output reg reconfig_busy
);
	localparam ST_FACT_CFG = 2'h0;
	localparam ST_FACT_USER = 2'h1;
	localparam ST_APP_CFG = 2'h2;
	localparam ST_APP_USER = 2'h3;

	reg [1:0] state_reg;
	reg [`RURC_CTL_W-1:0] control_reg;
	reg [`RURC_CTL_W-1:0] update_reg;
	reg core_trig_d_reg;
	reg app_seen_reg;
	reg [15:0] cfg_cnt_reg;
	wire core_rise;
	wire [4:0] src_req;
	wire [4:0] src_pick;
	wire wd_expired;
	wire wd_enable;
	wire exit_event;
	wire [`RURC_REC_W-1:0] new_record;
	wire [1:0] msm_code;

	assign core_rise = core_reconfig_trigger_n && !core_trig_d_reg;
	assign src_req = {!external_reconfig_request_n, crc_error, !config_fault_status_n, wd_expired,
		core_rise && (state_reg == ST_FACT_USER)};
	assign exit_event = |src_req;
	assign wd_enable = (state_reg == ST_APP_USER) && control_reg[`RURC_CTL_WDEN];
	assign msm_code = (state_reg == ST_APP_USER) ? `RURC_MSM_APP_USER :
		(state_reg == ST_APP_CFG) ? `RURC_MSM_APP_CFG :
		(state_reg == ST_FACT_CFG) ? `RURC_MSM_FACT_CFG : `RURC_MSM_FACTORY;
	assign new_record = {src_pick, msm_code, control_reg[`RURC_CTL_AD_HI:`RURC_CTL_AD_LO]};

	rurc_source_pick #(
		.W(5)
	) u_pick (
		.req(src_req),
		.onehot(src_pick)
	);

	rurc_watchdog #(
		.SET_W(`RURC_WD_SET_W),
		.LOW_W(`RURC_WD_LOW_W)
	) u_wd (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.enable(wd_enable),
		.osc_tick(osc_tick),
		.reload(!watchdog_reload_n),
		.setting(control_reg[`RURC_CTL_WD_HI:`RURC_CTL_WD_LO]),
		.expired(wd_expired)
	);

	always @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state_reg <= ST_FACT_CFG;
			control_reg <= {`RURC_CTL_W{1'b0}};
			update_reg <= {`RURC_CTL_W{1'b0}};
			core_trig_d_reg <= 1'b1;
			app_seen_reg <= 1'b0;
			cfg_cnt_reg <= 16'h0000;
			earlier_exit_record_one <= `RURC_INVALID_REC;
			earlier_exit_record_two <= `RURC_INVALID_REC;
			watchdog_expired_flag <= 1'b0;
		end
		else
		begin
			core_trig_d_reg <= core_reconfig_trigger_n;
			if (update_write && state_reg == ST_FACT_USER)
				update_reg <= update_wdata;
			if (exit_event && state_reg != ST_FACT_CFG)
			begin
				if (state_reg == ST_APP_USER || state_reg == ST_APP_CFG)
				begin
					earlier_exit_record_two <= earlier_exit_record_one;
					earlier_exit_record_one <= new_record;
				end
				watchdog_expired_flag <= src_pick[`RURC_SRC_WD - `RURC_SRC_CORE];
				cfg_cnt_reg <= 16'h0000;
				if (src_pick[0])
				begin
					control_reg <= update_reg;
					state_reg <= ST_APP_CFG;
				end
				else
				begin
					control_reg <= {`RURC_CTL_W{1'b0}};
					state_reg <= ST_FACT_CFG;
				end
			end
			else
			begin
				case (state_reg)
					ST_FACT_CFG, ST_APP_CFG:
					begin
						if (cfg_cnt_reg == CFG_CYCLES[15:0])
						begin
							state_reg <= (state_reg == ST_APP_CFG) ? ST_APP_USER : ST_FACT_USER;
							cfg_cnt_reg <= 16'h0000;
							if (state_reg == ST_APP_CFG)
								app_seen_reg <= 1'b1;
						end
						else
							cfg_cnt_reg <= cfg_cnt_reg + 16'h0001;
					end
					ST_FACT_USER, ST_APP_USER:
						cfg_cnt_reg <= 16'h0000;
					default:
						state_reg <= ST_FACT_CFG;
				endcase
			end
		end
	end

	always @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			reg_rdata <= {`RURC_CTL_W{1'b0}};
			record_rdata <= {`RURC_REC_W{1'b0}};
			msm_state <= 2'h0;
			factory_loaded <= 1'b1;
			reconfig_busy <= 1'b1;
		end
		else
		begin
			reg_rdata <= (state_reg == ST_FACT_USER) ? update_reg : control_reg;
			if (capture_record_one || capture_record_two)
				record_rdata <= !app_seen_reg ? `RURC_INVALID_REC :
					(capture_record_two ? earlier_exit_record_two : earlier_exit_record_one);
			msm_state <= msm_code;
			factory_loaded <= (state_reg == ST_FACT_CFG) || (state_reg == ST_FACT_USER);
			reconfig_busy <= (state_reg == ST_FACT_CFG) || (state_reg == ST_APP_CFG);
		end
	end
endmodule

// [tb/rurc_monitor.sv]
// assertion checker bound to the controller top
`timescale 1ns/1ps
module rurc_monitor(
	input ref_clk,
	input reset_n,
	input [40:0] reg_rdata,
	input [30:0] record_rdata,
	input capture_record_two,
	input [30:0] earlier_exit_record_one,
	input [30:0] earlier_exit_record_two,
	input [1:0] msm_state,
	input factory_loaded,
	input watchdog_expired_flag,
	input reconfig_busy
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	wire v1 = earlier_exit_record_one != 31'h7FFFFFFF;
	src_onehot_a: assert property (v1 |-> $onehot(earlier_exit_record_one[30:26]))
		else $error("exit source not one-hot");
	rec_shift_a: assert property ($changed(earlier_exit_record_one) |->
		earlier_exit_record_two == $past(earlier_exit_record_one)) else $error("record did not shift");
	wd_state_a: assert property (v1 && earlier_exit_record_one[27] |->
		earlier_exit_record_one[25:24] == 2'h2) else $error("watchdog exit outside app user");
	wd_flag_a: assert property ($rose(watchdog_expired_flag) |-> ##[0:2] earlier_exit_record_one[27])
		else $error("flag without watchdog record");
	flag_clear_a: assert property ($changed(earlier_exit_record_one) && v1 && !earlier_exit_record_one[27]
		|-> ##[0:2] !watchdog_expired_flag) else $error("flag kept after other exit");
	app_user_a: assert property (msm_state == 2'h2 |-> !factory_loaded && !reconfig_busy)
		else $error("app user state flags wrong");
	app_cfg_a: assert property (msm_state == 2'h1 |-> reconfig_busy && !factory_loaded)
		else $error("app config state flags wrong");
	app_read_a: assert property ($rose(msm_state == 2'h2) |-> $stable(reg_rdata))
		else $error("read data moved entering app");
	cap_two_a: assert property (capture_record_two && $stable(earlier_exit_record_two) |=>
		record_rdata == $past(earlier_exit_record_two)) else $error("capture mismatch");
endmodule
bind rurc_ctrl rurc_monitor rurc_monitor_i(.ref_clk(ref_clk), .reset_n(reset_n), .reg_rdata(reg_rdata),
	.record_rdata(record_rdata), .capture_record_two(capture_record_two),
	.earlier_exit_record_one(earlier_exit_record_one), .earlier_exit_record_two(earlier_exit_record_two),
	.msm_state(msm_state), .factory_loaded(factory_loaded), .watchdog_expired_flag(watchdog_expired_flag),
	.reconfig_busy(reconfig_busy));

// [tb/rurc_user_model.sv]
// user fabric logic: update writes and watchdog reloads
`timescale 1ns/1ps
module rurc_user_model(
	input wire ref_clk,
	input wire [1:0] msm_state,
	input wire kick,
	input wire wr,
	input wire [40:0] val,
	output reg update_write,
	output reg [40:0] update_wdata,
	output reg watchdog_reload_n
);
	initial
	begin
		update_write = 1'h0;
		update_wdata = 41'h0;
		watchdog_reload_n = 1'h1;
	end
	always @(posedge ref_clk)
	begin
		update_write <= #1 wr;
		update_wdata <= #1 wr ? val : ~update_wdata;
		watchdog_reload_n <= #1 !(kick && msm_state == 2'h2);
	end
endmodule

// [tb/remote_upgrade_reconfig_control_test.sv]
// self-checking bench for the reconfiguration controller
`timescale 1ns/1ps
module remote_upgrade_reconfig_control_test;
	reg ref_clk = 0, reset_n = 0, ext_n = 1, stat_n = 1, crc = 0, trig_n = 1, osc = 0;
	reg cap1 = 0, cap2 = 0, kick = 0, wr = 0;
	reg [40:0] val = 0;
	reg [30:0] prev, old, exp_rec;
	reg [8:0] rows [0:5];
	integer n_fail = 0, samples_checked = 0, i, k;
	wire upd_w, rel_n, fl, wdf, busy;
	wire [40:0] upd_d, rdata;
	wire [30:0] rrec, r1, r2;
	wire [1:0] msm;
	always #2.5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) osc <= #1 ~osc;
	rurc_ctrl #(.CFG_CYCLES(4)) rurc_ctrl_i(.ref_clk(ref_clk), .reset_n(reset_n),
		.external_reconfig_request_n(ext_n), .config_fault_status_n(stat_n), .crc_error(crc),
		.core_reconfig_trigger_n(trig_n), .watchdog_reload_n(rel_n), .osc_tick(osc), .update_write(upd_w),
		.update_wdata(upd_d), .capture_record_one(cap1), .capture_record_two(cap2), .reg_rdata(rdata),
		.record_rdata(rrec), .earlier_exit_record_one(r1), .earlier_exit_record_two(r2), .msm_state(msm),
		.factory_loaded(fl), .watchdog_expired_flag(wdf), .reconfig_busy(busy));
	rurc_user_model rurc_user_model_i(.ref_clk(ref_clk), .msm_state(msm), .kick(kick), .wr(wr), .val(val),
		.update_write(upd_w), .update_wdata(upd_d), .watchdog_reload_n(rel_n));
	task chk(input [40:0] got, input [40:0] want);
		samples_checked++;
		if (got !== want)
		begin
			n_fail++;
			$display("[FAIL] %0t got %h want %h", $time, got, want);
		end
	endtask
	task cyc(input integer n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task till(input [1:0] s);
		k = 0;
		while (msm !== s && k < 200)
		begin
			cyc(1);
			k++;
		end
		if (k == 200) n_fail++;
	endtask
	task close_out;
		$display("checks %0d fails %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial
	begin
		#300000;
		n_fail++;
		close_out;
	end
	initial
	begin
		rows[0] = 9'h090;
		rows[1] = 9'h048;
		rows[2] = 9'h102;
		rows[3] = 9'h024;
		rows[4] = 9'h0F0;
		rows[5] = 9'h068;
		cyc(6);
		chk(fl, 1'h1);
		chk(r1, 31'h7FFFFFFF);
		reset_n = 1;
		cyc(2);
		till(2'h0);
		cap2 = 1;
		cyc(1);
		cap2 = 0;
		cyc(1);
		chk(rrec, 31'h7FFFFFFF);
		prev = 31'h7FFFFFFF;
		kick = 1;
		for (i = 0; i < 6; i++)
		begin
			till(2'h0);
			val = {2'h0, rows[i][8], 12'h000, 2'h0, 24'h000100 + i[23:0]};
			wr = 1;
			cyc(1);
			wr = 0;
			cyc(3);
			chk(rdata, val);
			trig_n = 0;
			cyc(1);
			trig_n = 1;
			till(2'h2);
			chk(rdata, val);
			chk(fl, 1'h0);
			kick = !rows[i][8];
			ext_n = !rows[i][7];
			crc = rows[i][6];
			stat_n = !rows[i][5];
			cyc(1);
			ext_n = 1;
			crc = 0;
			stat_n = 1;
			till(2'h3);
			chk(rdata, 41'h0);
			chk(busy, 1'h1);
			till(2'h0);
			exp_rec = {rows[i][4:0], 2'h2, val[23:0]};
			chk(r1, exp_rec);
			chk(r2, prev);
			chk(wdf, rows[i][8]);
			old = prev;
			prev = exp_rec;
			kick = 1;
		end
		cap1 = 1;
		cyc(1);
		cap1 = 0;
		cyc(1);
		chk(rrec, prev);
		cap1 = 1;
		cap2 = 1;
		cyc(1);
		cap1 = 0;
		cap2 = 0;
		cyc(1);
		chk(rrec, old);
		trig_n = 0;
		cyc(1);
		trig_n = 1;
		till(2'h2);
		val = ~val;
		wr = 1;
		cyc(1);
		wr = 0;
		cyc(3);
		chk(rdata, ~val);
		reset_n = 0;
		cyc(2);
		chk(r2, 31'h7FFFFFFF);
		reset_n = 1;
		close_out;
	end
endmodule
